//--- hdl/dsw_consts.svh
// Constants for the serial DAC write port
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH
`define DSW_FRAME_BITS   16
`define DSW_CNT_W        5
`define DSW_MODE_HI      13
`define DSW_MODE_LO      12
`define DSW_DATA_HI      11
`define DSW_DATA_LO      4
`define DSW_DATA_RST     8'h00
`define DSW_MODE_RST     2'h0
`endif

//--- hdl/dsw_pkg.sv
// Types for the serial DAC write port
`default_nettype none
package dsw_pkg;
    typedef enum logic [1:0] {
        DSW_NORMAL    = 2'h0,
        DSW_PD_MODE_1 = 2'h1,
        DSW_PD_MODE_2 = 2'h2,
        DSW_PD_MODE_3 = 2'h3
    } dsw_mode_type;
    typedef enum logic [1:0] {
        DSW_IDLE  = 2'h0,
        DSW_SHIFT = 2'h1,
        DSW_DONE  = 2'h3
    } dsw_state_type;
endpackage
`default_nettype wire

//--- hdl/dsw_sync_if.sv
// Interface carrying synchronised link pins and their edges
`timescale 1ns/100ps
`default_nettype none
interface dsw_sync_if;
    logic sclk_fall;
    logic frame_low;
    logic frame_fall;
    logic frame_rise;
    logic data;
    modport src (output sclk_fall, frame_low, frame_fall, frame_rise, data);
    modport dst (input sclk_fall, frame_low, frame_fall, frame_rise, data);
endinterface
`default_nettype wire

//--- hdl/dsw_pin_sync.sv
// Two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/100ps
`default_nettype none
module dsw_pin_sync (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic sclk,
    input  wire logic sync_n,
    input  wire logic din,
    dsw_sync_if.src   pins
);
    logic [2:0] meta;
    logic [2:0] stable;
    logic [2:0] last;
    logic [2:0] next_meta;
    logic [2:0] next_stable;
    logic [2:0] next_last;

    always_comb begin
        next_meta   = {sclk, sync_n, din};
        next_stable = meta;
        next_last   = stable;
    end

    // Idle pin levels: clock high, frame select high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta   <= 3'h6;
            stable <= 3'h6;
            last   <= 3'h6;
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
            last   <= next_last;
        end
    end

    assign pins.sclk_fall  = last[2] & ~stable[2];
    assign pins.frame_low  = ~stable[1];
    assign pins.frame_fall = last[1] & ~stable[1];
    assign pins.frame_rise = ~last[1] & stable[1];
    assign pins.data       = stable[0];
endmodule
`default_nettype wire

//--- hdl/dsw_port.sv
// Serial write port of an 8-bit DAC: shift register, update and abort
//
// Summary of operation
// - Sixteen-bit input shift register takes every frame
// - Data sampled on the first sixteen falling serial clock edges of a frame
// - Active-low frame select enables shifting while low
// - Sixteenth falling edge loads DAC register and mode
// - Early frame select rise aborts, no update
// - Layout: two ignored, two mode, eight data, four ignored
// - Mode bits pick normal or three power-downs
// - Abort clears shift register, keeps data and mode
`timescale 1ns/100ps
`default_nettype none
`include "dsw_consts.svh"
module dsw_port #(
    parameter int FRAME_BITS = `DSW_FRAME_BITS
) (
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic            sclk,
    input  wire logic            sync_n,
    input  wire logic            din,
    output var  logic [7:0]      dac_code,
    output var  dsw_pkg::dsw_mode_type op_mode,
    output var  logic            update,
    output var  logic            abort,
    output var  logic            busy
);
    dsw_sync_if pins ();

    dsw_pin_sync u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .sclk    (sclk),
        .sync_n  (sync_n),
        .din     (din),
        .pins    (pins)
    );

    localparam int CNT_W   = `DSW_CNT_W;
    // Field positions in the frame
    localparam int DATA_HI = `DSW_DATA_HI;
    localparam int DATA_LO = `DSW_DATA_LO;
    localparam int MODE_HI = `DSW_MODE_HI;
    localparam int MODE_LO = `DSW_MODE_LO;
    // Count value while the last bit of a frame is due
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);

    // Sequencer, shift register and the next values of the outputs
    dsw_pkg::dsw_state_type   state;
    dsw_pkg::dsw_state_type   next_state;
    logic [FRAME_BITS-1:0]    shreg;
    logic [FRAME_BITS-1:0]    next_shreg;
    logic [CNT_W-1:0]         count;
    logic [CNT_W-1:0]         next_count;
    logic [7:0]               next_dac_code;
    dsw_pkg::dsw_mode_type    next_op_mode;
    logic                     next_update;
    logic                     next_abort;
    logic                     next_busy;
    logic                     frame_start;
    logic                     frame_cut;
    logic                     bit_strobe;
    logic                     last_bit;
    logic                     frame_done;

    // Shift one bit in at the bottom: the first bit sent ends at the top
    function automatic logic [FRAME_BITS-1:0] shift_in(
        input logic [FRAME_BITS-1:0] frame,
        input logic                  bit_in
    );
        shift_in = {frame[FRAME_BITS-2:0], bit_in};
    endfunction

    // Data field of a full frame
    function automatic logic [7:0] frame_data(
        input logic [FRAME_BITS-1:0] frame
    );
        frame_data = frame[DATA_HI:DATA_LO];
    endfunction

    // Mode field of a full frame
    function automatic dsw_pkg::dsw_mode_type frame_mode(
        input logic [FRAME_BITS-1:0] frame
    );
        frame_mode = dsw_pkg::dsw_mode_type'(frame[MODE_HI:MODE_LO]);
    endfunction

    // Events of the current cycle, decoded once for all groups
    always_comb begin
        frame_start = (state == dsw_pkg::DSW_IDLE) && pins.frame_fall;
        // A rise seen together with the last clock edge still counts as a cut
        frame_cut   = (state == dsw_pkg::DSW_SHIFT)
                      && (pins.frame_rise || !pins.frame_low);
        // Clock edges outside the shifting state are refused
        bit_strobe  = (state == dsw_pkg::DSW_SHIFT)
                      && !frame_cut && pins.sclk_fall;
        last_bit    = (count == LAST_BIT);
        frame_done  = bit_strobe && last_bit;
    end

    // Frame sequencer: idle, shifting, and done waiting for frame select high
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            dsw_pkg::DSW_IDLE: begin
                // A new frame only starts on a falling frame select
                if (frame_start) begin
                    next_state = dsw_pkg::DSW_SHIFT;
                    next_count = '0;
                end
            end
            dsw_pkg::DSW_SHIFT: begin
                if (frame_cut) begin
                    next_state = dsw_pkg::DSW_IDLE;
                    next_count = '0;
                end else if (bit_strobe) begin
                    next_count = count + CNT_W'(1);
                    if (last_bit) begin
                        next_state = dsw_pkg::DSW_DONE;
                    end
                end
            end
            dsw_pkg::DSW_DONE: begin
                // Frame select may stay low here; further clocks are ignored
                if (!pins.frame_low) begin
                    next_state = dsw_pkg::DSW_IDLE;
                    next_count = '0;
                end
            end
            default: begin
                next_state = dsw_pkg::DSW_IDLE;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= dsw_pkg::DSW_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Clearing at the start too keeps a stale partial frame from leaking in
    always_comb begin
        next_shreg = shreg;
        if (frame_start) begin
            next_shreg = '0;
        end else if (frame_cut) begin
            next_shreg = '0;
        end else if (bit_strobe) begin
            next_shreg = shift_in(shreg, pins.data);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shreg <= '0;
        end else begin
            shreg <= next_shreg;
        end
    end

    // The last bit is merged here, as it is not in the shift register yet
    always_comb begin
        next_dac_code = dac_code;
        next_op_mode  = op_mode;
        if (frame_done) begin
            next_dac_code = frame_data(shift_in(shreg, pins.data));
            next_op_mode  = frame_mode(shift_in(shreg, pins.data));
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dac_code <= `DSW_DATA_RST;
            op_mode  <= dsw_pkg::dsw_mode_type'(`DSW_MODE_RST);
        end else begin
            dac_code <= next_dac_code;
            op_mode  <= next_op_mode;
        end
    end

    // One-cycle pulses that report how each frame ended
    always_comb begin
        next_update = frame_done;
        next_abort  = frame_cut;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            update <= 1'b0;
            abort  <= 1'b0;
        end else begin
            update <= next_update;
            abort  <= next_abort;
        end
    end

    // Busy follows the sequencer into and out of the shifting state
    always_comb begin
        next_busy = (next_state == dsw_pkg::DSW_SHIFT);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end
endmodule
`default_nettype wire

//--- tb/dsw_port_sva.sv
// Pin-level assertions for the serial DAC write port
`timescale 1ns/100ps
`default_nettype none
module dsw_port_sva (
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic            sync_n,
    input  wire logic [7:0]      dac_code,
    input  var  dsw_pkg::dsw_mode_type op_mode,
    input  wire logic            update,
    input  wire logic            abort,
    input  wire logic            busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_upd; update |=> !update; endproperty
    a_upd: assert property (p_upd) else $error("update too long");
    property p_ab; abort |=> !abort; endproperty
    a_ab: assert property (p_ab) else $error("abort too long");
    property p_excl; !(update && abort); endproperty
    a_excl: assert property (p_excl) else $error("update with abort");
    property p_hold; !update |-> $stable({dac_code, op_mode}); endproperty
    a_hold: assert property (p_hold) else $error("load without update");
    property p_end; update |-> !busy && $past(busy); endproperty
    a_end: assert property (p_end) else $error("update outside frame");
    property p_absel; abort |-> sync_n && $past(sync_n, 2) && !busy; endproperty
    a_absel: assert property (p_absel) else $error("abort w/o select rise");
    property p_start; $rose(busy) |-> !sync_n; endproperty
    a_start: assert property (p_start) else $error("start w/o select");
    property p_ab2; abort |-> $past(busy); endproperty
    a_ab2: assert property (p_ab2) else $error("abort when idle");
endmodule
`default_nettype wire

//--- tb/dsw_host.sv
// Host model driving one write frame on the three pins
`timescale 1ns/100ps
`default_nettype none
module dsw_host (
    output var logic sclk,
    output var logic sync_n,
    output var logic din
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    task automatic frame(input logic [15:0] word, input int nbits, input int extra);
        sync_n = 1'b0;
        #100;
        for (int i = 15; i > 15 - nbits; i--) begin
            din = word[i];
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        // Clocks after a full frame with frame select still low must be ignored
        for (int i = 0; i < extra; i++) begin
            din = ~din;
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        #80 sync_n = 1'b1;
        din = ~din;
        #300;
    endtask
endmodule
`default_nettype wire

//--- tb/dsw_port_tb.sv
// Self-checking bench for the serial DAC write port
`timescale 1ns/100ps
`default_nettype none
module dsw_port_tb;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        sclk, sync_n, din, update, abort, busy;
    logic [7:0]  dac_code;
    logic [15:0] w;
    dsw_pkg::dsw_mode_type op_mode;
    int          err_count = 0, num_checks = 0, cycles = 0;
    int          n_upd = 0, n_ab = 0, e_upd = 0, e_ab = 0, e_code = 0, e_mode = 0;
    int          n_start = 0, exp_next = 0;
    int          exp_q[$];
    logic        busy_q = 1'b0;
    dsw_port dsw_port_i (.sys_clk, .rstn, .sclk, .sync_n, .din, .dac_code, .op_mode,
                         .update, .abort, .busy);
    dsw_host dsw_host_i (.sclk, .sync_n, .din);
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        n_upd += update;
        n_ab += abort;
        n_start += busy && !busy_q;
        busy_q = busy;
        if (update) begin
            exp_next = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0000ffff;
            check({6'h00, op_mode, dac_code}, exp_next[15:0]);
        end
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        w = 16'($urandom(32'ha9de));
        #152 rstn = 1'b1;
        #200;
        for (int t = 0; t < 12; t++) begin
            int n;
            int x;
            w = 16'($urandom());
            n = (t < 8) ? 16 : (t == 8) ? 15 : $urandom_range(1, 14);
            // Full frames 4 to 7 keep frame select low for a few extra clocks
            x = (t >= 4 && t < 8) ? $urandom_range(1, 3) : 0;
            if (t < 4) w[13:12] = t[1:0];
            if (n == 16) begin
                e_code = w[11:4];
                e_mode = w[13:12];
                e_upd++;
                exp_q.push_back({6'h00, w[13:4]});
            end else begin
                e_ab++;
            end
            dsw_host_i.frame(w, n, x);
            check(dac_code, e_code[15:0]);
            check(op_mode, e_mode[15:0]);
            check(n_upd[15:0], e_upd[15:0]);
            check(n_ab[15:0], e_ab[15:0]);
            check(busy, 16'h0000);
            check(n_start[15:0], 16'(t + 1));
            check(16'(exp_q.size()), 16'h0000);
            $display("test %0d bits %0d done", t, n);
        end
        tally_and_finish();
    end
endmodule
bind dsw_port dsw_port_sva dsw_port_sva_i (.sys_clk, .rstn, .sync_n, .dac_code, .op_mode,
                                           .update, .abort, .busy);
`default_nettype wire
